// ==== verilog/gri_regs.sv ====
// Purpose: Soft reset, data-ready interrupt pins and self-test registers
// Assumes: Serial front end delivers single-cycle register strobes
// Notes: Read data is valid one cycle after reg_rd_en
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (R01) Writing the key to the soft-reset register starts a reset; others ignored.
// (R02) After the reset delay, all configuration registers return to defaults.
// (R03) Soft reset is accepted in every power mode.
// (R04) Enable register 0x80 enables data-ready interrupts; 0x00 disables; resets 0x00.
// (R05) Config bit 3 picks pin B drive: push-pull or open-drain.
// (R06) Config bit 2 picks pin B asserted level: low or high.
// (R07) Config bit 1 picks pin A drive: push-pull or open-drain.
// (R08) Config bit 0 picks pin A asserted level: low or high.
// (R09) Routing 0x00 sends data-ready to no pin; it is the default.
// (R10) Routing 0x01 sends data-ready to pin A only.
// (R11) Routing 0x80 sends data-ready to pin B only.
// (R12) Routing 0x81 sends data-ready to both pins.
// (R13) Writing one to self-test bit 0 starts the self-test.
// (R14) Self-test ready bit 1 sets on completion; zero after reset.
// (R15) With ready set, bit 2 reports fail as one, pass as zero.
// (R16) Bit 4 shows sensor healthy; zero after reset.
// (R17) Data-ready events follow the output rate chosen by the rate code.
// (R18) Host spaces register writes by at least 2 us, or 1000 us suspended.
// (R19) Pins without an enabled routed source stay inactive or released.
// (R20) Open-drain pins drive only the asserted level, float otherwise.
module gri_regs
  import gri_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = gri_pkg::SOFT_RESET_DELAY_CYCLES,
  parameter int unsigned SELF_TEST_RUN_CYCLES = gri_pkg::SELF_TEST_CYCLES,
  parameter int unsigned SAMPLE_PERIOD_CYCLES = gri_pkg::SAMPLE_BASE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [gri_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gri_pkg::DATA_W-1:0] reg_wdata,
  output logic [gri_pkg::DATA_W-1:0] reg_rdata_r,
  output logic reg_rd_valid_r,
  input wire logic [2:0] rate_filter_code,
  input wire logic [1:0] power_mode,
  input wire logic sensor_healthy,
  input wire logic self_test_fault,
  output logic soft_reset_busy_r,
  output logic self_test_busy_r,
  output logic sample_tick_r,
  output logic irq_pin_a_out_r,
  output logic irq_pin_a_oe_r,
  output logic irq_pin_b_out_r,
  output logic irq_pin_b_oe_r
);
  import gri_pkg::*;

  localparam int unsigned SR_CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
  localparam int unsigned ST_CNT_W = $clog2(SELF_TEST_RUN_CYCLES + 1);
  localparam int unsigned SMP_CNT_W = $clog2(SAMPLE_PERIOD_CYCLES + 1);
  localparam int unsigned DRDY_CNT_W = $clog2(DRDY_PULSE_CYCLES + 1);
  localparam logic [SR_CNT_W-1:0] SR_LAST =
    SR_CNT_W'(SOFT_RESET_CYCLES - 1);
  localparam logic [ST_CNT_W-1:0] ST_LAST =
    ST_CNT_W'(SELF_TEST_RUN_CYCLES - 1);
  localparam logic [SMP_CNT_W-1:0] SMP_LAST =
    SMP_CNT_W'(SAMPLE_PERIOD_CYCLES - 1);
  localparam logic [DRDY_CNT_W-1:0] DRDY_LEN =
    DRDY_CNT_W'(DRDY_PULSE_CYCLES);

  // Decoded write strobes
  logic wr_soft_reset;
  logic wr_irq_enable;
  logic wr_pin_config;
  logic wr_routing;
  logic wr_self_test;

  assign wr_soft_reset = reg_wr_en && (reg_addr == SOFT_RESET_COMMAND_OFS);
  assign wr_irq_enable = reg_wr_en && (reg_addr == NEW_SAMPLE_IRQ_ENABLE_OFS);
  assign wr_pin_config = reg_wr_en &&
    (reg_addr == IRQ_PIN_ELECTRICAL_CONFIG_OFS);
  assign wr_routing = reg_wr_en && (reg_addr == IRQ_PIN_ROUTING_OFS);
  assign wr_self_test = reg_wr_en &&
    (reg_addr == SELF_CHECK_CONTROL_STATUS_OFS);

  // Soft reset sequencer
  gri_soft_reset_e sr_state_r;
  logic [SR_CNT_W-1:0] sr_cnt_r;
  logic sr_key_hit;
  logic sr_restore;

  // Power mode is deliberately not consulted here
  assign sr_key_hit = wr_soft_reset && (reg_wdata == SOFT_RESET_KEY); // R01 R03
  assign sr_restore = (sr_state_r == GRI_SR_WAIT) && (sr_cnt_r == SR_LAST);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sr_state_r <= GRI_SR_IDLE;
      sr_cnt_r <= '0;
    end
    else
    begin
      unique case (sr_state_r)
        GRI_SR_IDLE:
        begin
          sr_cnt_r <= '0;
          if (sr_key_hit)
          begin
            sr_state_r <= GRI_SR_WAIT; // R01
          end
        end
        GRI_SR_WAIT:
        begin
          // A repeated key restarts the full delay
          if (sr_key_hit)
          begin
            sr_cnt_r <= '0;
          end
          else if (sr_restore)
          begin
            sr_state_r <= GRI_SR_IDLE; // R02
            sr_cnt_r <= '0;
          end
          else
          begin
            sr_cnt_r <= sr_cnt_r + 1'b1; // R02
          end
        end
        default:
        begin
          sr_state_r <= GRI_SR_IDLE;
          sr_cnt_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      soft_reset_busy_r <= 1'b0;
    end
    else
    begin
      soft_reset_busy_r <= ((sr_state_r == GRI_SR_WAIT) && !sr_restore) ||
        sr_key_hit;
    end
  end

  // Configuration registers
  logic [7:0] irq_enable_r;
  logic [3:0] pin_config_r;
  logic [7:0] route_code_r;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_enable_r <= IRQ_ENABLE_RST; // R04
    end
    else if (sr_restore)
    begin
      irq_enable_r <= IRQ_ENABLE_RST; // R02
    end
    else if (wr_irq_enable)
    begin
      irq_enable_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      pin_config_r <= PIN_CONFIG_RST; // R05 R06 R07 R08
    end
    else if (sr_restore)
    begin
      pin_config_r <= PIN_CONFIG_RST; // R02
    end
    else if (wr_pin_config)
    begin
      pin_config_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      route_code_r <= ROUTE_RST; // R09
    end
    else if (sr_restore)
    begin
      route_code_r <= ROUTE_RST; // R02
    end
    else if (wr_routing)
    begin
      route_code_r <= reg_wdata;
    end
  end

  // Self-test sequencer
  gri_self_test_e st_state_r;
  logic [ST_CNT_W-1:0] st_cnt_r;
  logic st_start;
  logic st_done;
  logic st_ready_r;
  logic st_fail_r;
  logic healthy_r;

  assign st_start = wr_self_test && reg_wdata[SELF_TEST_TRIGGER_BIT]; // R13
  assign st_done = (st_state_r == GRI_ST_RUN) && (st_cnt_r == ST_LAST);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_state_r <= GRI_ST_IDLE;
      st_cnt_r <= '0;
    end
    else if (sr_restore)
    begin
      st_state_r <= GRI_ST_IDLE;
      st_cnt_r <= '0;
    end
    else
    begin
      unique case (st_state_r)
        GRI_ST_IDLE:
        begin
          st_cnt_r <= '0;
          if (st_start)
          begin
            st_state_r <= GRI_ST_RUN; // R13
          end
        end
        GRI_ST_RUN:
        begin
          // Retrigger while running restarts the test
          if (st_start)
          begin
            st_cnt_r <= '0;
          end
          else if (st_done)
          begin
            st_state_r <= GRI_ST_IDLE;
            st_cnt_r <= '0;
          end
          else
          begin
            st_cnt_r <= st_cnt_r + 1'b1;
          end
        end
        default:
        begin
          st_state_r <= GRI_ST_IDLE;
          st_cnt_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_ready_r <= 1'b0; // R14
      st_fail_r <= 1'b0;
    end
    else if (sr_restore)
    begin
      st_ready_r <= 1'b0;
      st_fail_r <= 1'b0;
    end
    else if (st_done && !st_start)
    begin
      st_ready_r <= 1'b1; // R14
      st_fail_r <= self_test_fault; // R15
    end
    else if (st_start)
    begin
      // Stale result must not be read as the new one
      st_ready_r <= 1'b0;
      st_fail_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      healthy_r <= 1'b0; // R16
      self_test_busy_r <= 1'b0;
    end
    else
    begin
      healthy_r <= sensor_healthy && (sr_state_r == GRI_SR_IDLE); // R16
      // Restore aborts the test, so busy drops on that same edge
      self_test_busy_r <= ((st_state_r == GRI_ST_RUN) && !st_done ||
        st_start) && !sr_restore;
    end
  end

  // Sample clock: base 2000 Hz tick, then divided per rate code
  logic [SMP_CNT_W-1:0] smp_cnt_r;
  logic [4:0] div_cnt_r;
  logic [4:0] div_len;
  logic base_tick;

  always_comb
  begin
    unique case (rate_filter_code)
      3'h0, 3'h1: div_len = RATE_DIV_X1;
      3'h2: div_len = RATE_DIV_X2;
      3'h3: div_len = RATE_DIV_X5;
      3'h4, 3'h6: div_len = RATE_DIV_X10;
      3'h5, 3'h7: div_len = RATE_DIV_X20;
    endcase
  end

  assign base_tick = (smp_cnt_r == SMP_LAST);

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      smp_cnt_r <= '0;
      div_cnt_r <= '0;
      sample_tick_r <= 1'b0;
    end
    else
    begin
      sample_tick_r <= 1'b0;
      smp_cnt_r <= base_tick ? '0 : smp_cnt_r + 1'b1;
      if (base_tick)
      begin
        // Guard against a code change shrinking the divider mid-count
        if (div_cnt_r + 1'b1 >= div_len)
        begin
          div_cnt_r <= '0;
          sample_tick_r <= 1'b1; // R17
        end
        else
        begin
          div_cnt_r <= div_cnt_r + 1'b1; // R17
        end
      end
    end
  end

  // Data-ready pulse, stretched so slow hosts can see it
  logic [DRDY_CNT_W-1:0] drdy_cnt_r;
  logic drdy_enabled;
  logic drdy_active;
  logic route_a;
  logic route_b;

  assign drdy_enabled = (irq_enable_r == IRQ_ENABLE_ON); // R04
  assign drdy_active = (drdy_cnt_r != '0);
  assign route_a = (route_code_r == ROUTE_PIN_A) ||
    (route_code_r == ROUTE_BOTH); // R10 R12
  assign route_b = (route_code_r == ROUTE_PIN_B) ||
    (route_code_r == ROUTE_BOTH); // R11 R12

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      drdy_cnt_r <= '0;
    end
    else if (!drdy_enabled)
    begin
      drdy_cnt_r <= '0; // R04
    end
    else if (sample_tick_r)
    begin
      drdy_cnt_r <= DRDY_LEN;
    end
    else if (drdy_active)
    begin
      drdy_cnt_r <= drdy_cnt_r - 1'b1;
    end
  end

  // Unrouted pins see no request; other route codes act as none
  gri_irq_pin u_pin_a
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .assert_req(drdy_active && route_a), // R09 R10 R19
    .active_high(pin_config_r[PIN_A_ACTIVE_HIGH_BIT]), // R08
    .open_drain(pin_config_r[PIN_A_OPEN_DRAIN_BIT]), // R07
    .pin_out_r(irq_pin_a_out_r),
    .pin_oe_r(irq_pin_a_oe_r)
  );

  gri_irq_pin u_pin_b
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .assert_req(drdy_active && route_b), // R09 R11 R19
    .active_high(pin_config_r[PIN_B_ACTIVE_HIGH_BIT]), // R06
    .open_drain(pin_config_r[PIN_B_OPEN_DRAIN_BIT]), // R05
    .pin_out_r(irq_pin_b_out_r),
    .pin_oe_r(irq_pin_b_oe_r)
  );

  // Read path; write-only and unmapped addresses read zero
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      NEW_SAMPLE_IRQ_ENABLE_OFS: rd_mux = irq_enable_r;
      IRQ_PIN_ELECTRICAL_CONFIG_OFS: rd_mux = {4'h0, pin_config_r};
      IRQ_PIN_ROUTING_OFS: rd_mux = route_code_r;
      SELF_CHECK_CONTROL_STATUS_OFS:
      begin
        rd_mux[SENSOR_HEALTHY_BIT] = healthy_r; // R16
        rd_mux[SELF_TEST_FAIL_BIT] = st_fail_r && st_ready_r; // R15
        rd_mux[SELF_TEST_READY_BIT] = st_ready_r; // R14
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Writes are taken in one cycle; host write spacing gives margin
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata_r <= 8'h00;
      reg_rd_valid_r <= 1'b0;
    end
    else
    begin
      reg_rd_valid_r <= reg_rd_en; // R18
      if (reg_rd_en)
      begin
        reg_rdata_r <= rd_mux;
      end
    end
  end

  // Power mode only matters to the sensor core, not to this bank
  logic power_mode_unused;
  assign power_mode_unused = ^power_mode; // R03

endmodule
`default_nettype wire

// ==== verilog/gri_pkg.sv ====
// Purpose: Shared constants for the gyro reset, interrupt and self-test bank
// Assumes: 250 MHz ref_clk, 7-bit register addresses, 8-bit data
// Notes: Long counts are defaults for module parameters of the top level
package gri_pkg;

  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [6:0] SOFT_RESET_COMMAND_OFS = 7'h14;
  localparam logic [6:0] NEW_SAMPLE_IRQ_ENABLE_OFS = 7'h15;
  localparam logic [6:0] IRQ_PIN_ELECTRICAL_CONFIG_OFS = 7'h16;
  localparam logic [6:0] IRQ_PIN_ROUTING_OFS = 7'h18;
  localparam logic [6:0] SELF_CHECK_CONTROL_STATUS_OFS = 7'h3c;

  // Command and code values
  localparam logic [7:0] SOFT_RESET_KEY = 8'hb6;
  localparam logic [7:0] IRQ_ENABLE_ON = 8'h80;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] ROUTE_NONE = 8'h00;
  localparam logic [7:0] ROUTE_PIN_A = 8'h01;
  localparam logic [7:0] ROUTE_PIN_B = 8'h80;
  localparam logic [7:0] ROUTE_BOTH = 8'h81;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [3:0] PIN_CONFIG_RST = 4'h0;

  // Field positions
  localparam int unsigned PIN_B_OPEN_DRAIN_BIT = 3;
  localparam int unsigned PIN_B_ACTIVE_HIGH_BIT = 2;
  localparam int unsigned PIN_A_OPEN_DRAIN_BIT = 1;
  localparam int unsigned PIN_A_ACTIVE_HIGH_BIT = 0;
  localparam int unsigned SELF_TEST_TRIGGER_BIT = 0;
  localparam int unsigned SELF_TEST_READY_BIT = 1;
  localparam int unsigned SELF_TEST_FAIL_BIT = 2;
  localparam int unsigned SENSOR_HEALTHY_BIT = 4;

  // Timing
  localparam int unsigned SOFT_RESET_DELAY_MS = 30;
  localparam int unsigned SOFT_RESET_DELAY_CYCLES =
    SOFT_RESET_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned SELF_TEST_TIME_US = 50;
  localparam int unsigned SELF_TEST_CYCLES =
    SELF_TEST_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned SAMPLE_BASE_RATE_HZ = 2000;
  localparam int unsigned SAMPLE_BASE_CYCLES = CLK_HZ / SAMPLE_BASE_RATE_HZ;
  localparam int unsigned DRDY_PULSE_NS = 256;
  localparam int unsigned DRDY_PULSE_CYCLES =
    (DRDY_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // Rate divider multiples of the 2000 Hz base, five values shared by the eight rate codes
  localparam logic [4:0] RATE_DIV_X1 = 5'h01;
  localparam logic [4:0] RATE_DIV_X2 = 5'h02;
  localparam logic [4:0] RATE_DIV_X5 = 5'h05;
  localparam logic [4:0] RATE_DIV_X10 = 5'h0a;
  localparam logic [4:0] RATE_DIV_X20 = 5'h14;

  typedef enum logic [1:0]
  {
    GRI_SR_IDLE = 2'b01,
    GRI_SR_WAIT = 2'b10
  } gri_soft_reset_e;

  typedef enum logic [1:0]
  {
    GRI_ST_IDLE = 2'b01,
    GRI_ST_RUN = 2'b10
  } gri_self_test_e;

endpackage

// ==== verilog/gri_irq_pin.sv ====
// Purpose: Drives one interrupt pin with selectable level and drive type
// Assumes: assert_req is a same-clock level
// Notes: Output and enable are registered; the pad resolves the wire
`timescale 1ns/100ps
`default_nettype none
module gri_irq_pin
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic assert_req,
  input wire logic active_high,
  input wire logic open_drain,
  output logic pin_out_r,
  output logic pin_oe_r
);

  logic pin_out_nxt;
  logic pin_oe_nxt;

  always_comb
  begin
    if (open_drain)
    begin
      // Released unless asserted; no fight with other drivers on the net
      pin_oe_nxt = assert_req; // R20 R19
      pin_out_nxt = active_high;
    end
    else
    begin
      pin_oe_nxt = 1'b1;
      pin_out_nxt = assert_req ? active_high : ~active_high; // R19
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      // Default config is push-pull active low, so idle level is high
      pin_out_r <= 1'b1;
      pin_oe_r <= 1'b1;
    end
    else
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== tb/gri_regs_asserts.sv ====
// Purpose: Port-level checks for gri_regs
// Assumes: One ref_clk domain, async active-high reset
// Notes: Counters stand in for waits too long to repeat
`timescale 1ns/100ps
`default_nettype none
module gri_regs_asserts
  import gri_pkg::*;
#(
  parameter int unsigned SOFT_RESET_CYCLES = 20,
  parameter int unsigned SELF_TEST_RUN_CYCLES = 10
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [gri_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gri_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [gri_pkg::DATA_W-1:0] reg_rdata_r,
  input wire logic reg_rd_valid_r,
  input wire logic [2:0] rate_filter_code,
  input wire logic soft_reset_busy_r,
  input wire logic self_test_busy_r,
  input wire logic sample_tick_r,
  input wire logic irq_pin_a_out_r,
  input wire logic irq_pin_a_oe_r,
  input wire logic irq_pin_b_out_r,
  input wire logic irq_pin_b_oe_r
);
  import gri_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic sr_wr;
  logic key_wr;
  logic st_wr;
  logic [31:0] sr_cnt_r;
  logic [31:0] st_cnt_r;
  assign sr_wr = reg_wr_en && reg_addr == SOFT_RESET_COMMAND_OFS;
  assign key_wr = sr_wr && reg_wdata == SOFT_RESET_KEY;
  assign st_wr = reg_wr_en && reg_addr == SELF_CHECK_CONTROL_STATUS_OFS &&
    reg_wdata[0];
  // A new key or trigger restarts the count
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      sr_cnt_r <= '0;
    else
      sr_cnt_r <= (key_wr || !soft_reset_busy_r) ? '0 : sr_cnt_r + 1;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      st_cnt_r <= '0;
    else
      st_cnt_r <= (st_wr || !self_test_busy_r) ? '0 : st_cnt_r + 1;
  AST_SR_START: assert property (key_wr |=> soft_reset_busy_r)
    else $error("soft reset did not start");
  AST_SR_IGNORE: assert property (
    sr_wr && !key_wr && !soft_reset_busy_r |=> !soft_reset_busy_r)
    else $error("soft reset started by a wrong value");
  AST_SR_LEN: assert property (
    $fell(soft_reset_busy_r) |-> sr_cnt_r == SOFT_RESET_CYCLES)
    else $error("soft reset delay length wrong");
  AST_SR_RESTORE: assert property ($fell(soft_reset_busy_r) |-> ##2
    (irq_pin_a_out_r && irq_pin_a_oe_r && irq_pin_b_out_r && irq_pin_b_oe_r))
    else $error("pins not idle after restore");
  AST_ST_START: assert property (
    st_wr && !soft_reset_busy_r |=> self_test_busy_r)
    else $error("self-test did not start");
  AST_ST_LEN: assert property (
    $fell(self_test_busy_r) && !$fell(soft_reset_busy_r) |->
    st_cnt_r == SELF_TEST_RUN_CYCLES)
    else $error("self-test length wrong");
  AST_RD_WO: assert property (
    reg_rd_en && reg_addr == SOFT_RESET_COMMAND_OFS |=>
    reg_rd_valid_r && reg_rdata_r == 8'h00)
    else $error("soft reset register not read as zero");
  AST_TICK_GAP: assert property (
    sample_tick_r && rate_filter_code < 3'h2 |=> !sample_tick_r [*8])
    else $error("samples too close together");
  COV_KEY: cover property (key_wr);
  COV_ST_DONE: cover property ($fell(self_test_busy_r));
  COV_B_HIGH: cover property (irq_pin_b_oe_r && irq_pin_b_out_r);
  COV_A_LOW: cover property (irq_pin_a_oe_r && !irq_pin_a_out_r);
endmodule
bind gri_regs gri_regs_asserts #(
  .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES),
  .SELF_TEST_RUN_CYCLES(SELF_TEST_RUN_CYCLES)
) i_chk (
  .ref_clk(ref_clk), .reset(reset), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_r(reg_rdata_r), .reg_rd_valid_r(reg_rd_valid_r),
  .rate_filter_code(rate_filter_code),
  .soft_reset_busy_r(soft_reset_busy_r), .self_test_busy_r(self_test_busy_r),
  .sample_tick_r(sample_tick_r), .irq_pin_a_out_r(irq_pin_a_out_r),
  .irq_pin_a_oe_r(irq_pin_a_oe_r), .irq_pin_b_out_r(irq_pin_b_out_r),
  .irq_pin_b_oe_r(irq_pin_b_oe_r)
);
`default_nettype wire

// ==== tb/gri_host_model.sv ====
// Purpose: Host side of the register strobe port
// Assumes: Tasks are entered at a falling edge
// Notes: Idle address and data show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module gri_host_model
  import gri_pkg::*;
#(
  parameter int unsigned GAP_CYCLES = 500
)
(
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [gri_pkg::ADDR_W-1:0] reg_addr,
  output logic [gri_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [gri_pkg::DATA_W-1:0] reg_rdata_r,
  input wire logic reg_rd_valid_r
);
  import gri_pkg::*;
  int unsigned cyc = 0;
  int unsigned last_wr = 0;
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
  end
  always @(posedge ref_clk)
    cyc <= cyc + 1;
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    // Written data needs 2 us to settle inside
    while (cyc - last_wr < GAP_CYCLES)
      @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    last_wr = cyc;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    // Valid stands one cycle only
    d = (reg_rd_valid_r === 1'b1) ? reg_rdata_r : 8'hxx;
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for gri_regs
// Assumes: Short counts set by parameters
// Notes: Row table covers rate codes and pin setups
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import gri_pkg::*;
  localparam int unsigned LIMIT = 60000;
  typedef struct packed
  {
    logic [2:0] rate;
    logic [7:0] en;
    logic [7:0] route;
    logic [3:0] conf;
    logic [9:0] per;
    logic a;
    logic b;
  } gri_row_s;
  gri_row_s rows [15] = '{
    '{3'h0, 8'h00, 8'h00, 4'h0, 10'h010, 1'b0, 1'b0},
    '{3'h1, 8'h00, 8'h00, 4'h0, 10'h010, 1'b0, 1'b0},
    '{3'h2, 8'h00, 8'h00, 4'h0, 10'h020, 1'b0, 1'b0},
    '{3'h3, 8'h00, 8'h00, 4'h0, 10'h050, 1'b0, 1'b0},
    '{3'h4, 8'h00, 8'h00, 4'h0, 10'h0a0, 1'b0, 1'b0},
    '{3'h5, 8'h00, 8'h00, 4'h0, 10'h140, 1'b0, 1'b0},
    '{3'h6, 8'h00, 8'h00, 4'h0, 10'h0a0, 1'b0, 1'b0},
    '{3'h7, 8'h00, 8'h00, 4'h0, 10'h140, 1'b0, 1'b0},
    '{3'h3, 8'h80, 8'h01, 4'h0, 10'h050, 1'b1, 1'b0},
    '{3'h3, 8'h80, 8'h80, 4'hf, 10'h050, 1'b0, 1'b1},
    '{3'h3, 8'h80, 8'h81, 4'h5, 10'h050, 1'b1, 1'b1},
    '{3'h3, 8'h80, 8'h81, 4'ha, 10'h050, 1'b1, 1'b1},
    '{3'h3, 8'h00, 8'h81, 4'h0, 10'h050, 1'b0, 1'b0},
    '{3'h3, 8'h80, 8'h02, 4'h3, 10'h050, 1'b0, 1'b0},
    '{3'h3, 8'h40, 8'h81, 4'hc, 10'h050, 1'b0, 1'b0}};
  logic ref_clk, reset, reg_wr_en, reg_rd_en, reg_rd_valid_r;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r, d;
  logic [2:0] rate_filter_code;
  logic [1:0] power_mode;
  logic sensor_healthy, self_test_fault, soft_reset_busy_r;
  logic self_test_busy_r, sample_tick_r, a_out, a_oe, b_out, b_oe;
  int unsigned fail_count = 0, checks = 0, cyc = 0, n;
  gri_regs #(
    .SOFT_RESET_CYCLES(20),
    .SELF_TEST_RUN_CYCLES(10),
    .SAMPLE_PERIOD_CYCLES(16)
  ) i_dut (
    .ref_clk(ref_clk), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rd_valid_r(reg_rd_valid_r),
    .rate_filter_code(rate_filter_code), .power_mode(power_mode),
    .sensor_healthy(sensor_healthy), .self_test_fault(self_test_fault),
    .soft_reset_busy_r(soft_reset_busy_r),
    .self_test_busy_r(self_test_busy_r), .sample_tick_r(sample_tick_r),
    .irq_pin_a_out_r(a_out), .irq_pin_a_oe_r(a_oe),
    .irq_pin_b_out_r(b_out), .irq_pin_b_oe_r(b_oe));
  gri_host_model i_host (
    .ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .reg_rd_valid_r(reg_rd_valid_r));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] e, g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk("rdata", {2'h0, e}, {2'h0, d});
  endtask
  // Open-drain idle leaves out unchecked: the pad floats
  task automatic pin1(input string nm, input logic on, lvl, od, oe, out);
    chk({nm, "_oe"}, {9'h0, on | !od}, {9'h0, oe});
    if (on | !od)
      chk({nm, "_out"}, {9'h0, on ? lvl : !lvl}, {9'h0, out});
  endtask
  task automatic tick(output int unsigned k);
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while (sample_tick_r !== 1'b1 && k < 400);
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    reset = 1'b1;
    rate_filter_code = 3'h0;
    power_mode = 2'h0;
    sensor_healthy = 1'b0;
    self_test_fault = 1'b0;
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    pin1("pin_a", 1'b0, 1'b0, 1'b0, a_oe, a_out);
    pin1("pin_b", 1'b0, 1'b0, 1'b0, b_oe, b_out);
    rdchk(7'h15, 8'h00);
    rdchk(7'h16, 8'h00);
    rdchk(7'h18, 8'h00);
    rdchk(7'h3c, 8'h00);
    rdchk(7'h14, 8'h00);
    rdchk(7'h20, 8'h00);
    i_host.wr(7'h16, 8'hff);
    rdchk(7'h16, 8'h0f);
    foreach (rows[i])
    begin
      rate_filter_code = rows[i].rate;
      i_host.wr(7'h15, rows[i].en);
      i_host.wr(7'h16, {4'h0, rows[i].conf});
      i_host.wr(7'h18, rows[i].route);
      tick(n);
      tick(n);
      chk("period", rows[i].per, n[9:0]);
      repeat (10) @(negedge ref_clk);
      pin1("pin_a", rows[i].a, rows[i].conf[0], rows[i].conf[1], a_oe,
        a_out);
      pin1("pin_b", rows[i].b, rows[i].conf[2], rows[i].conf[3], b_oe,
        b_out);
      repeat (65) @(negedge ref_clk);
      pin1("pin_a", 1'b0, rows[i].conf[0], rows[i].conf[1], a_oe,
        a_out);
      pin1("pin_b", 1'b0, rows[i].conf[2], rows[i].conf[3], b_oe,
        b_out);
    end
    sensor_healthy = 1'b1;
    i_host.wr(7'h3c, 8'h01);
    chk("st_busy", 10'h001, {9'h0, self_test_busy_r});
    repeat (20) @(negedge ref_clk);
    rdchk(7'h3c, 8'h12);
    self_test_fault = 1'b1;
    i_host.wr(7'h3c, 8'h01);
    rdchk(7'h3c, 8'h10);
    repeat (20) @(negedge ref_clk);
    rdchk(7'h3c, 8'h16);
    i_host.wr(7'h3c, 8'h00);
    chk("st_busy", 10'h000, {9'h0, self_test_busy_r});
    sensor_healthy = 1'b0;
    // Healthy flag is registered, so it shows one cycle later
    @(negedge ref_clk);
    rdchk(7'h3c, 8'h06);
    i_host.wr(7'h3c, 8'h01);
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    chk("st_busy", 10'h000, {9'h0, self_test_busy_r});
    rdchk(7'h3c, 8'h00);
    i_host.wr(7'h15, 8'h80);
    i_host.wr(7'h18, 8'h81);
    i_host.wr(7'h14, 8'h12);
    chk("sr_busy", 10'h000, {9'h0, soft_reset_busy_r});
    rdchk(7'h15, 8'h80);
    i_host.wr(7'h3c, 8'h01);
    repeat (20) @(negedge ref_clk);
    power_mode = 2'h2;
    i_host.wr(7'h14, 8'hb6);
    chk("sr_busy", 10'h001, {9'h0, soft_reset_busy_r});
    n = 0;
    while (soft_reset_busy_r === 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("sr_busy", 10'h000, {9'h0, soft_reset_busy_r});
    power_mode = 2'h0;
    rdchk(7'h15, 8'h00);
    rdchk(7'h18, 8'h00);
    rdchk(7'h3c, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
